// File: src/ueb_pkg.sv
package ueb_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] UEB_ADDR_CSR  = 8'h00;
	localparam logic [7:0] UEB_ADDR_FIFO = 8'h04;
	localparam logic [7:0] UEB_ADDR_CFG  = 8'h08;

	// ----------------------------------------------------------------
	// Control/status field positions
	// ----------------------------------------------------------------
	localparam int UEB_B_TX_COMPLETE   = 0;
	localparam int UEB_B_RXBK0    = 1;
	localparam int UEB_B_RXBK1    = 6;
	localparam int UEB_B_TXRDY    = 4;
	localparam int UEB_B_CNT_LO   = 16;
	localparam int UEB_CNT_W      = 7;
	localparam int UEB_B_PP       = 0;
	localparam int UEB_B_DIR_IN   = 1;

	// ----------------------------------------------------------------
	// Bank geometry and timing
	// ----------------------------------------------------------------
	localparam int UEB_DEPTH      = 64;
	localparam int UEB_PTR_W      = 6;
	localparam int UEB_CLK_MHZ    = 100;
	localparam int UEB_LINK_MHZ   = 12;
	localparam int UEB_BIT_DIV    = UEB_CLK_MHZ / UEB_LINK_MHZ;
	localparam logic [3:0] UEB_BIT_DIV_M1 = 4'(UEB_BIT_DIV - 1);

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {UEB_HS_ACK, UEB_HS_NAK, UEB_HS_DATA} ueb_hs_t;

	typedef struct packed {
		logic       in_token;
		logic       out_start;
		logic       out_byte;
		logic [7:0] out_data;
		logic       out_end;
		logic       host_ack;
		logic       in_pop;
	} ueb_link_in_t;

	typedef struct packed {
		logic       hs_valid;
		ueb_hs_t    hs;
		logic [7:0] in_data;
		logic       in_last;
	} ueb_link_out_t;

endpackage

// File: src/ueb_bank.sv
`timescale 1ns/1ps
module ueb_bank
	import ueb_pkg::*;
(
	// Clock
	input  wire logic                 hclk,
	// Write port
	input  wire logic                 we,
	input  wire logic [UEB_PTR_W:0]   waddr,
	input  wire logic [7:0]           wdata,
	// Read port
	input  wire logic [UEB_PTR_W:0]   raddr,
	output logic      [7:0]           rdata
);
	// Two banks of bytes; top address bit picks the bank
	logic [7:0] mem [0:2*UEB_DEPTH-1];

	always_ff @(posedge hclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	assign rdata = mem[raddr];
endmodule

// File: src/ueb_endpoint.sv
// Implementation choices: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
module ueb_endpoint
	import ueb_pkg::*;
(
	// AHB-Lite slave
	input  wire logic          hclk,
	input  wire logic          hresetn,
	input  wire logic          hsel,
	input  wire logic [7:0]    haddr,
	input  wire logic [1:0]    htrans,
	input  wire logic          hwrite,
	input  wire logic [2:0]    hsize,
	input  wire logic [31:0]   hwdata,
	input  wire logic          hready,
	output logic      [31:0]   hrdata,
	output logic               hreadyout,
	output logic               hresp,
	// Bus-side link
	input  wire ueb_link_in_t  link_i,
	output ueb_link_out_t      link_o,
	// Endpoint interrupt
	output logic               ep_irq
);
	// ----------------------------------------------------------------
	// Bit-rate enable
	// ----------------------------------------------------------------
	logic [3:0] div_q;
	logic       bit_en;
	assign bit_en = (div_q == UEB_BIT_DIV_M1);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) div_q <= 4'h0;
		else div_q <= bit_en ? 4'h0 : div_q + 4'h1;
	end

	// Link strobes only count on the bit-rate enable
	logic tok, ostart, obyte, oend, hack, ipop;
	assign tok    = bit_en && link_i.in_token;
	assign ostart = bit_en && link_i.out_start;
	assign obyte  = bit_en && link_i.out_byte;
	assign oend   = bit_en && link_i.out_end;
	assign hack   = bit_en && link_i.host_ack;
	assign ipop   = bit_en && link_i.in_pop;

	// ----------------------------------------------------------------
	// AHB address phase capture
	// ----------------------------------------------------------------
	logic       aw_q, ar_q;
	logic [7:0] aa_q;
	logic       acc;
	assign acc = hsel && hready && htrans[1];
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			aw_q <= 1'b0;
			ar_q <= 1'b0;
			aa_q <= 8'h00;
		end else begin
			aw_q <= acc && hwrite;
			ar_q <= acc && !hwrite;
			aa_q <= haddr;
		end
	end
	logic wr_csr, wr_fifo, wr_cfg, rd_fifo;
	assign wr_csr  = aw_q && (aa_q == UEB_ADDR_CSR);
	assign wr_fifo = aw_q && (aa_q == UEB_ADDR_FIFO);
	assign wr_cfg  = aw_q && (aa_q == UEB_ADDR_CFG);
	assign rd_fifo = acc && !hwrite && (haddr == UEB_ADDR_FIFO);

	// ----------------------------------------------------------------
	// Configuration and flags
	// ----------------------------------------------------------------
	logic pp_q, dir_in_q;
	logic txrdy_q, tx_complete_q, rx0_q, rx1_q;
	logic [1:0] txfull_q;      // Bank holds a readied IN payload
	logic tx_bus_bk_q, tx_fw_bk_q, rx_bus_bk_q, rx_fw_bk_q;
	logic [UEB_PTR_W:0] wcnt_q, rcnt_q, bus_ptr_q;
	logic [UEB_PTR_W:0] cnt0_q, cnt1_q;
	logic sending_q, rxing_q, rx_drop_q;
	// Pointer step at full pointer width, so no sum is silently widened
	localparam logic [UEB_PTR_W:0] PTR_ONE = {{UEB_PTR_W{1'b0}}, 1'b1};

	logic clr_tx_complete, set_txrdy, clr_rx0, clr_rx1;
	assign clr_tx_complete = wr_csr && !hwdata[UEB_B_TX_COMPLETE];
	assign set_txrdy  = wr_csr && hwdata[UEB_B_TXRDY] && !txrdy_q;
	assign clr_rx0    = wr_csr && !hwdata[UEB_B_RXBK0];
	assign clr_rx1    = wr_csr && !hwdata[UEB_B_RXBK1];

	function automatic logic bank_busy(input logic pp, input logic b,
		input logic f0, input logic f1);
		bank_busy = pp ? (b ? f1 : f0) : (f0 | f1);
	endfunction

	// IN side: bus may send when its bank is readied by firmware
	logic in_ok, in_nak, in_done;
	assign in_ok   = tok && dir_in_q && txfull_q[tx_bus_bk_q] && !sending_q;
	assign in_nak  = tok && dir_in_q && !in_ok;
	assign in_done = hack && sending_q;

	// OUT side: accept only into a bank firmware has released
	logic out_free, out_acc, out_fin;
	assign out_free = !bank_busy(pp_q, rx_bus_bk_q, rx0_q, rx1_q);
	assign out_acc  = ostart && !dir_in_q && out_free;
	assign out_fin  = oend && rxing_q;

	// Firmware-side and bus-side bank pointers for IN and OUT
	logic [UEB_PTR_W:0] fw_wa, fw_ra, bus_wa, bus_ra;
	assign fw_wa  = {tx_fw_bk_q, wcnt_q[UEB_PTR_W-1:0]};
	assign fw_ra  = {rx_fw_bk_q, rcnt_q[UEB_PTR_W-1:0]};
	assign bus_wa = {rx_bus_bk_q, bus_ptr_q[UEB_PTR_W-1:0]};
	assign bus_ra = {tx_bus_bk_q, bus_ptr_q[UEB_PTR_W-1:0]};

	logic        mem_we;
	logic [UEB_PTR_W:0] mem_wa, mem_ra;
	logic [7:0]  mem_wd, mem_rd;
	logic        bus_wr;
	assign bus_wr = obyte && rxing_q && !bus_ptr_q[UEB_PTR_W];
	assign mem_we = bus_wr || (wr_fifo && dir_in_q && !wcnt_q[UEB_PTR_W]);
	assign mem_wa = bus_wr ? bus_wa : fw_wa;
	assign mem_wd = bus_wr ? link_i.out_data : hwdata[7:0];
	assign mem_ra = dir_in_q ? bus_ra : fw_ra;

	ueb_bank u_bank (
		.hclk  (hclk),
		.we    (mem_we),
		.waddr (mem_wa),
		.wdata (mem_wd),
		.raddr (mem_ra),
		.rdata (mem_rd)
	);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pp_q     <= 1'b0;
			dir_in_q <= 1'b0;
		end else if (wr_cfg) begin
			pp_q     <= hwdata[UEB_B_PP];
			dir_in_q <= hwdata[UEB_B_DIR_IN];
		end
	end

	// IN path
	logic [1:0] rdy_bank;
	assign rdy_bank = pp_q ? (2'b01 << tx_fw_bk_q) : 2'b01;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			txrdy_q     <= 1'b0;
			tx_complete_q    <= 1'b0;
			txfull_q    <= 2'b00;
			tx_bus_bk_q <= 1'b0;
			tx_fw_bk_q  <= 1'b0;
			wcnt_q      <= '0;
			sending_q   <= 1'b0;
		end else begin
			if (in_ok) sending_q <= 1'b1;
			else if (in_done || tok) sending_q <= 1'b0;
			if (wr_fifo && dir_in_q && !wcnt_q[UEB_PTR_W]) wcnt_q <= wcnt_q + PTR_ONE;
			if (set_txrdy) begin
				txrdy_q  <= 1'b1;
				txfull_q <= txfull_q | rdy_bank;
				wcnt_q   <= '0;
				if (pp_q) tx_fw_bk_q <= !tx_fw_bk_q;
			end else if (in_done) begin
				txrdy_q <= 1'b0;
			end
			if (in_done) begin
				txfull_q[tx_bus_bk_q] <= 1'b0;
				if (pp_q) tx_bus_bk_q <= !tx_bus_bk_q;
			end
			if (in_done) tx_complete_q <= 1'b1;
			else if (clr_tx_complete) tx_complete_q <= 1'b0;
		end
	end

	// Per-bank IN length follows firmware fill count
	logic [UEB_PTR_W:0] in_len;
	assign in_len = tx_bus_bk_q ? cnt1_q : cnt0_q;

	// OUT path
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx0_q       <= 1'b0;
			rx1_q       <= 1'b0;
			rx_bus_bk_q <= 1'b0;
			rx_fw_bk_q  <= 1'b0;
			rcnt_q      <= '0;
			bus_ptr_q   <= '0;
			cnt0_q      <= '0;
			cnt1_q      <= '0;
			rxing_q     <= 1'b0;
			rx_drop_q   <= 1'b0;
		end else begin
			rx_drop_q <= 1'b0;
			if (out_acc || in_ok) bus_ptr_q <= '0;
			else if (bus_wr || (ipop && sending_q)) bus_ptr_q <= bus_ptr_q + PTR_ONE;
			if (out_acc) rxing_q <= 1'b1;
			else if (out_fin) rxing_q <= 1'b0;
			if (set_txrdy) begin
				if (tx_fw_bk_q && pp_q) cnt1_q <= wcnt_q;
				else cnt0_q <= wcnt_q;
			end
			if (out_fin) begin
				if (rx_bus_bk_q) cnt1_q <= bus_ptr_q;
				else cnt0_q <= bus_ptr_q;
				if (pp_q) rx_bus_bk_q <= !rx_bus_bk_q;
			end
			if (out_fin && !rx_bus_bk_q) rx0_q <= 1'b1;
			else if (clr_rx0) rx0_q <= 1'b0;
			if (out_fin && rx_bus_bk_q) rx1_q <= 1'b1;
			else if (clr_rx1) rx1_q <= 1'b0;
			if ((clr_rx0 && rx0_q) || (clr_rx1 && rx1_q)) begin
				rcnt_q <= '0;
				if (pp_q) rx_fw_bk_q <= !rx_fw_bk_q;
			end else if (rd_fifo && !dir_in_q) begin
				rcnt_q <= rcnt_q + PTR_ONE;
			end
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	logic [UEB_PTR_W:0] rx_cnt;
	logic [31:0]        csr_val, rd_val;
	assign rx_cnt  = rx_fw_bk_q ? cnt1_q : cnt0_q;
	assign csr_val = (32'(rx_cnt) << UEB_B_CNT_LO)
		| (32'(rx1_q) << UEB_B_RXBK1) | (32'(txrdy_q) << UEB_B_TXRDY)
		| (32'(rx0_q) << UEB_B_RXBK0) | (32'(tx_complete_q) << UEB_B_TX_COMPLETE);
	assign rd_val  = (haddr == UEB_ADDR_CSR)  ? csr_val :
		(haddr == UEB_ADDR_FIFO) ? {24'h00_0000, mem_rd} :
		(haddr == UEB_ADDR_CFG)  ? ((32'(dir_in_q) << UEB_B_DIR_IN) | 32'(pp_q)) :
		32'h0000_0000;

	logic    last_byte;
	assign last_byte = (bus_ptr_q + PTR_ONE) >= in_len;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata         <= 32'h0000_0000;
			hreadyout      <= 1'b1;
			hresp          <= 1'b0;
			ep_irq         <= 1'b0;
			link_o         <= '0;
		end else begin
			if (acc && !hwrite) hrdata <= rd_val;
			ep_irq          <= tx_complete_q | rx0_q | rx1_q;
			link_o.hs_valid <= in_nak || out_fin || (ostart && !dir_in_q && !out_free) || in_ok;
			link_o.hs       <= in_ok ? UEB_HS_DATA : (in_nak || !out_free) ? UEB_HS_NAK
				: UEB_HS_ACK;
			link_o.in_data  <= mem_rd;
			link_o.in_last  <= sending_q && last_byte;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	tx_complete_cause_a:  assert property ($rose(tx_complete_q) |-> $past(in_done))
		else $error("tx_complete rose without host ack");
	irq_tx_complete_a:    assert property (tx_complete_q |=> ep_irq)
		else $error("irq low with tx_complete set");
	irq_rx_a:        assert property ((rx0_q || rx1_q) |=> ep_irq)
		else $error("irq low with receive bank full");
	nak_no_ready_a:  assert property (in_nak |=> link_o.hs_valid && link_o.hs == UEB_HS_NAK)
		else $error("IN without ready bank not NAKed");
	rx0_cause_a:     assert property ($rose(rx0_q) |-> $past(out_fin && !rx_bus_bk_q))
		else $error("rx_bank0_full rose without bank zero packet");
	rx1_cause_a:     assert property ($rose(rx1_q) |-> $past(out_fin && rx_bus_bk_q))
		else $error("rx_bank1_full rose without bank one packet");
	single_hold_a:   assert property (!pp_q && rx0_q && ostart && !dir_in_q |-> !out_acc)
		else $error("single-bank OUT accepted while full");
	out_nak_a:       assert property (ostart && !dir_in_q && !out_free |=>
		link_o.hs_valid && link_o.hs == UEB_HS_NAK)
		else $error("busy OUT packet not NAKed");
	out_ack_a:       assert property (out_fin |=>
		link_o.hs_valid && link_o.hs == UEB_HS_ACK)
		else $error("stored OUT packet not ACKed");
	pp_alt_a:        assert property (pp_q && out_fin |=> rx_bus_bk_q != $past(rx_bus_bk_q))
		else $error("receive bank did not alternate");
	ahb_okay_a:      assert property (hresp == 1'b0 && hreadyout)
		else $error("slave answer not OKAY ready");

	in_sent_c:   cover property (in_done);
	out_pp_c:    cover property (rx0_q && rx1_q);
	nak_c:       cover property (in_nak);
endmodule

// File: testbench/ueb_host_model.sv
`timescale 1ns/1ps
// ------------------------
// Host on the link
// ------------------------
module ueb_host_model
	import ueb_pkg::*;
(
	// Clock
	input  wire logic          hclk,
	// Link
	output ueb_link_in_t       link_i,
	input  wire ueb_link_out_t link_o
);
	ueb_hs_t    hs_q;
	int         hs_n = 0;
	logic [8:0] in_q [$];

	initial link_i = '0;

	// Sampled mid-cycle, clear of the launching edge
	always @(negedge hclk) begin
		if (link_o.hs_valid === 1'b1) begin
			hs_q <= link_o.hs;
			hs_n <= hs_n + 1;
		end
	end

	// Eight cycles meet one bit enable; idle data is inverted, not kept
	task automatic hold(input int k, input logic [7:0] d);
		ueb_link_in_t v;
		v = '0;
		case (k)
			0: v.in_token = 1'b1;
			1: v.out_start = 1'b1;
			2: v.out_byte = 1'b1;
			3: v.out_end = 1'b1;
			4: v.host_ack = 1'b1;
			default: v.in_pop = 1'b1;
		endcase
		v.out_data = d;
		link_i <= v;
		repeat (8) @(posedge hclk);
		link_i <= '{out_data: ~d, default: '0};
		repeat (2) @(posedge hclk);
	endtask

	task automatic send_out(input int n, input logic [7:0] base);
		hold(1, 8'h00);
		for (int i = 0; i < n; i++) begin
			hold(2, base + 8'(i));
		end
		hold(3, 8'h00);
	endtask

	task automatic recv_in(input int n);
		hold(0, 8'h00);
		for (int i = 0; i < n; i++) begin
			in_q.push_back({link_o.in_last, link_o.in_data});
			hold(5, 8'h00);
		end
	endtask
endmodule

// File: testbench/usb_endpoint_bank_handshake_tb.sv
`timescale 1ns/1ps
module usb_endpoint_bank_handshake_tb
	import ueb_pkg::*;
;
	localparam int WR = 0, RD = 1, PO = 2, TI = 3, HA = 4, IQ = 5, RS = 6;
	typedef struct {int op; int a; logic [31:0] d; logic [31:0] m;} ueb_row_t;

	logic          hclk, hresetn, hsel, hwrite;
	logic [7:0]    haddr;
	logic [1:0]    htrans;
	logic [2:0]    hsize;
	logic [31:0]   hwdata, hrdata, rd;
	logic          hreadyout, hresp, ep_irq;
	ueb_link_in_t  link_i;
	ueb_link_out_t link_o;
	int            error_cnt = 0, compares = 0, cyc = 0, n0;
	ueb_row_t      r;
	ueb_row_t      rows [] = '{
		'{WR, 8'h0C, 8'h5A, 0}, '{RD, 8'h0C, 0, '1}, '{RD, 8'h00, 0, '1},
		'{PO, 3, 8'hA0, UEB_HS_ACK},
		'{RD, 8'h00, 32'h0003_0002, 32'h007F_0053}, '{IQ, 0, 1, 0},
		'{PO, 2, 8'hB0, UEB_HS_NAK},
		'{RD, 8'h04, 8'hA0, 8'hFF}, '{RD, 8'h04, 8'hA1, 8'hFF},
		'{RD, 8'h04, 8'hA2, 8'hFF}, '{WR, 8'h00, 0, 0}, '{IQ, 0, 0, 0},
		'{PO, 0, 8'hC0, UEB_HS_ACK},
		'{RD, 8'h00, 32'h0000_0002, 32'h007F_0053}, '{WR, 8'h00, 0, 0},
		'{WR, 8'h08, 8'h02, 0}, '{TI, 0, 0, UEB_HS_NAK},
		'{WR, 8'h04, 8'h11, 0}, '{WR, 8'h04, 8'h12, 0}, '{WR, 8'h00, 8'h10, 0},
		'{TI, 2, 8'h11, UEB_HS_DATA}, '{RD, 8'h00, 8'h10, 8'h53},
		'{HA, 20, 0, 0}, '{RD, 8'h00, 8'h01, 8'h53}, '{IQ, 0, 1, 0},
		'{WR, 8'h00, 0, 0}, '{IQ, 0, 0, 0},
		'{RS, 0, 0, 0}, '{WR, 8'h08, 8'h03, 0}, '{RD, 8'h08, 8'h03, 8'h03},
		'{WR, 8'h04, 8'h31, 0},
		'{WR, 8'h00, 8'h10, 0}, '{WR, 8'h04, 8'h41, 0},
		'{TI, 1, 8'h31, UEB_HS_DATA}, '{HA, 0, 0, 0},
		'{RD, 8'h00, 8'h01, 8'h53}, '{WR, 8'h00, 8'h10, 0},
		'{TI, 1, 8'h41, UEB_HS_DATA}, '{HA, 0, 0, 0},
		'{WR, 8'h00, 0, 0}, '{TI, 0, 0, UEB_HS_NAK},
		'{RS, 0, 0, 0}, '{WR, 8'h08, 8'h01, 0},
		'{PO, 2, 8'h50, UEB_HS_ACK}, '{PO, 2, 8'h60, UEB_HS_ACK},
		'{PO, 1, 8'h70, UEB_HS_NAK},
		'{RD, 8'h00, 32'h0002_0042, 32'h007F_0043}, '{IQ, 0, 1, 0},
		'{RD, 8'h04, 8'h50, 8'hFF}, '{RD, 8'h04, 8'h51, 8'hFF},
		'{WR, 8'h00, 8'h40, 0}, '{RD, 8'h00, 32'h0002_0040, 32'h007F_0043},
		'{IQ, 0, 1, 0}, '{PO, 1, 8'h70, UEB_HS_ACK},
		'{RD, 8'h04, 8'h60, 8'hFF}, '{RD, 8'h04, 8'h61, 8'hFF},
		'{WR, 8'h00, 8'h02, 0}, '{RD, 8'h00, 32'h0001_0002, 32'h007F_0043},
		'{RD, 8'h04, 8'h70, 8'hFF}, '{WR, 8'h00, 0, 0}, '{IQ, 0, 0, 0}
	};

	ueb_endpoint u_ueb_endpoint (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hwdata    (hwdata),
		.hready    (hreadyout),
		.hrdata    (hrdata),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.link_i    (link_i),
		.link_o    (link_o),
		.ep_irq    (ep_irq)
	);

	ueb_host_model u_ueb_host_model (
		.hclk   (hclk),
		.link_i (link_i),
		.link_o (link_o)
	);

	// --------------------
	// Checking and bus
	// --------------------
	task automatic end_of_test();
		if (error_cnt == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] q);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= wr;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		q = hrdata;
	endtask

	task automatic do_reset(input int n);
		hresetn <= 1'b0;
		repeat (n) @(posedge hclk);
		chk({hreadyout, hresp, ep_irq}, 32'h0000_0004);
		hresetn <= 1'b1;
		@(posedge hclk);
	endtask

	// --------------------
	// Clock, limit, sequence
	// --------------------
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	// Whole run needs a few hundred cycles
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 8000) begin
			error_cnt++;
			end_of_test();
		end
	end

	initial begin
		hsel = 1'b0;
		haddr = 8'h00;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0000_0000;
		do_reset(16);
		foreach (rows[i]) begin
			r = rows[i];
			n0 = u_ueb_host_model.hs_n;
			case (r.op)
				WR: ahb(1'b1, 8'(r.a), r.d, rd);
				RD: begin
					ahb(1'b0, 8'(r.a), 32'h0000_0000, rd);
					chk(rd & r.m, r.d);
				end
				PO: begin
					u_ueb_host_model.send_out(r.a, r.d[7:0]);
					chk(u_ueb_host_model.hs_q, r.m);
					chk(32'(u_ueb_host_model.hs_n > n0), 32'h0000_0001);
				end
				TI: begin
					u_ueb_host_model.recv_in(r.a);
					chk(u_ueb_host_model.hs_q, r.m);
					for (int j = 0; j < r.a; j++) begin
						chk(u_ueb_host_model.in_q.pop_front(),
							32'({j == r.a - 1, r.d[7:0] + 8'(j)}));
					end
				end
				HA: begin
					repeat (r.a) @(posedge hclk);
					u_ueb_host_model.hold(4, 8'h00);
				end
				IQ: begin
					repeat (3) @(posedge hclk);
					chk(ep_irq, r.d);
				end
				default: do_reset(4);
			endcase
		end
		// Reset with a bank full must drop flags and interrupt
		u_ueb_host_model.send_out(1, 8'hE0);
		chk(ep_irq, 32'h0000_0001);
		do_reset(4);
		ahb(1'b0, UEB_ADDR_CSR, 32'h0000_0000, rd);
		chk(rd, 32'h0000_0000);
		end_of_test();
	end
endmodule
